/* File: verilog/clk_pwr_pkg.sv */
package clk_pwr_pkg;
  // register offsets on the special-function bus
  localparam logic [7:0] UNLOCK_KEY_ADDR = 8'hc1;
  localparam logic [7:0] POWER_CLOCK_CONTROL_ADDR = 8'hc5;
  localparam logic [7:0] CONVERSION_START_REG_ADDR = 8'hd8;
  localparam logic [7:0] PERIPHERAL_CONFIG_ADDR = 8'hf4;
  // key values
  localparam logic [7:0] POWER_KEY = 8'ha7;
  localparam logic [7:0] TIMEKEEP_KEY = 8'hea;
  localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;
  // power_clock_control fields and reset
  localparam int CORE_DIVIDER_LSB = 0;
  localparam int CORE_DIVIDER_W = 3;
  localparam int CORE_SHUTDOWN_BIT = 4;
  localparam int RESERVED5_BIT = 5;
  localparam int METERING_SHUTDOWN_BIT = 6;
  localparam int RESERVED7_BIT = 7;
  localparam logic [7:0] POWER_CLOCK_CONTROL_RESET = 8'h82;
  // flag and acknowledge positions
  localparam int LOCK_FAULT_FLAG_BIT = 4;
  localparam int LOCK_FAULT_ACK_BIT = 7;
  // clock figures
  localparam int REF_CLOCK_HZ = 32768;
  localparam int LOOP_CLOCK_HZ = 4096000;
  localparam int LOOP_MULT = LOOP_CLOCK_HZ / REF_CLOCK_HZ;
  localparam int METER_DIV = 5;
  localparam int CORE_CLK_HZ = 125000000;
  // processor reset pulse length after loss of lock
  localparam int FAULT_RESET_NS = 1000;
  localparam int FAULT_RESET_CYCLES = (FAULT_RESET_NS * (CORE_CLK_HZ / 1000000) + 999) / 1000;
endpackage

/* File: verilog/pow2_divider.sv */
`timescale 1ns/1ns
// divides an enable stream by 2**sel, one-cycle output pulses
module pow2_divider #(
  parameter int SEL_W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic [SEL_W-1:0] i_sel,
  output logic o_pulse
);
  localparam int CNT_W = (1 << SEL_W) - 1;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] mask;

  always_comb begin
    mask = CNT_W'((1 << i_sel) - 1);
    next_count = count;
    o_pulse = 1'b0;
    if (i_en) begin
      if ((count & mask) == mask) begin
        next_count = '0;
        o_pulse = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // pow2_divider

/* File: verilog/mod_divider.sv */
`timescale 1ns/1ns
// divides an enable stream by a fixed modulus
module mod_divider #(
  parameter int MOD = 5
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  output logic o_pulse
);
  localparam int CNT_W = $clog2(MOD + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(MOD - 1);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    o_pulse = 1'b0;
    if (i_en) begin
      if (count == LAST) begin
        next_count = '0;
        o_pulse = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // mod_divider

/* File: verilog/clk_pwr_ctrl.sv */
`timescale 1ns/1ns
module clk_pwr_ctrl
  import clk_pwr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ref_clk,
  input wire logic i_lock,
  input wire logic i_battery_power_state,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic i_timekeep_wr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic o_timekeep_unlock,
  output logic o_loop_clk_en,
  output logic o_core_clk_en,
  output logic o_meter_clk_en,
  output logic o_metering_shutdown,
  output logic o_core_shutdown,
  output logic o_cpu_reset,
  output logic o_lock_fault_flag,
  output logic [CORE_DIVIDER_W-1:0] o_core_divider
);
  import clk_pwr_pkg::*;

  localparam int RST_W = $clog2(FAULT_RESET_CYCLES + 2);
  localparam int NCO_W = 27;
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(LOOP_CLOCK_HZ / 1000);
  localparam logic [NCO_W-1:0] NCO_MOD = NCO_W'(CORE_CLK_HZ / 1000);

  // synchronisers for pins
  logic ref_s1, ref_s2, ref_s3;
  logic lock_s1, lock_s2, lock_s3;
  logic bat_s1, bat_s2;

  logic [7:0] unlock_key, next_unlock_key;
  logic [7:0] power_clock_control, next_power_clock_control;
  logic lock_fault_flag, next_lock_fault_flag;
  logic [RST_W-1:0] rst_cnt, next_rst_cnt;
  logic [NCO_W-1:0] nco, next_nco;
  logic loop_en, next_loop_en;
  logic ref_seen, next_ref_seen;
  logic core_pulse, meter_pulse;
  logic lock_lost;
  logic [7:0] rdata, next_rdata;
  logic hit;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_s3 <= 1'b0;
      bat_s1 <= 1'b0;
      bat_s2 <= 1'b0;
    end else begin
      ref_s1 <= i_ref_clk;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      lock_s1 <= i_lock;
      lock_s2 <= lock_s1;
      lock_s3 <= lock_s2;
      bat_s1 <= i_battery_power_state;
      bat_s2 <= bat_s1;
    end
  end

  // loop clock: nco at LOOP_MULT times the reference, held off until reference seen and locked
  always_comb begin
    next_ref_seen = ref_seen | (ref_s2 & ~ref_s3);
    next_loop_en = 1'b0;
    next_nco = nco;
    if (ref_seen && lock_s2) begin
      if (nco + NCO_STEP >= NCO_MOD) begin
        next_nco = nco + NCO_STEP - NCO_MOD;
        next_loop_en = 1'b1;
      end else begin
        next_nco = nco + NCO_STEP;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nco <= '0;
      loop_en <= 1'b0;
      ref_seen <= 1'b0;
    end else begin
      nco <= next_nco;
      loop_en <= next_loop_en;
      ref_seen <= next_ref_seen;
    end
  end

  pow2_divider #(.SEL_W(CORE_DIVIDER_W)) u_core_div (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_en(loop_en),
    .i_sel(power_clock_control[CORE_DIVIDER_LSB +: CORE_DIVIDER_W]),
    .o_pulse(core_pulse)
  );

  mod_divider #(.MOD(METER_DIV)) u_meter_div (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_en(loop_en),
    .o_pulse(meter_pulse)
  );

  assign lock_lost = lock_s3 & ~lock_s2;
  assign hit = addr_is(i_sfr_addr, UNLOCK_KEY_ADDR) | addr_is(i_sfr_addr, POWER_CLOCK_CONTROL_ADDR)
    | addr_is(i_sfr_addr, CONVERSION_START_REG_ADDR) | addr_is(i_sfr_addr, PERIPHERAL_CONFIG_ADDR);

  // register writes, key handling, fault flag
  always_comb begin
    next_unlock_key = unlock_key;
    next_power_clock_control = power_clock_control;
    next_lock_fault_flag = lock_fault_flag;
    next_rst_cnt = rst_cnt;
    if (i_sfr_wr && addr_is(i_sfr_addr, UNLOCK_KEY_ADDR)) begin
      next_unlock_key = i_sfr_wdata;
    end
    if (i_sfr_wr && addr_is(i_sfr_addr, POWER_CLOCK_CONTROL_ADDR)) begin
      if (unlock_key == POWER_KEY) begin
        next_power_clock_control = i_sfr_wdata;
        next_power_clock_control[RESERVED7_BIT] = 1'b1;
        next_power_clock_control[3] = 1'b0;
      end
      next_unlock_key = UNLOCK_KEY_RESET;
    end
    if (i_timekeep_wr && unlock_key == TIMEKEEP_KEY) begin
      next_unlock_key = UNLOCK_KEY_RESET;
    end
    if (i_sfr_wr && addr_is(i_sfr_addr, CONVERSION_START_REG_ADDR) && i_sfr_wdata[LOCK_FAULT_ACK_BIT]) begin
      next_lock_fault_flag = 1'b0;
    end
    if (lock_lost) begin
      next_lock_fault_flag = 1'b1; // set wins over ack
      next_rst_cnt = RST_W'(FAULT_RESET_CYCLES);
    end else if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - RST_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      unlock_key <= UNLOCK_KEY_RESET;
      power_clock_control <= POWER_CLOCK_CONTROL_RESET;
      lock_fault_flag <= 1'b0;
      rst_cnt <= '0;
    end else begin
      unlock_key <= next_unlock_key;
      power_clock_control <= next_power_clock_control;
      lock_fault_flag <= next_lock_fault_flag;
      rst_cnt <= next_rst_cnt;
    end
  end

  // read path, registered one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (i_sfr_rd) begin
      unique case (1'b1)
        addr_is(i_sfr_addr, UNLOCK_KEY_ADDR): next_rdata = unlock_key;
        addr_is(i_sfr_addr, POWER_CLOCK_CONTROL_ADDR): next_rdata = power_clock_control;
        addr_is(i_sfr_addr, PERIPHERAL_CONFIG_ADDR): next_rdata = 8'(lock_fault_flag) << LOCK_FAULT_FLAG_BIT;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_sfr_rdata = rdata;
  assign o_sfr_hit = hit;
  assign o_timekeep_unlock = (unlock_key == TIMEKEEP_KEY);
  assign o_loop_clk_en = loop_en;
  assign o_core_clk_en = core_pulse;
  assign o_meter_clk_en = meter_pulse;
  assign o_metering_shutdown = power_clock_control[METERING_SHUTDOWN_BIT];
  assign o_core_shutdown = power_clock_control[CORE_SHUTDOWN_BIT] & bat_s2;
  assign o_cpu_reset = (rst_cnt != '0);
  assign o_lock_fault_flag = lock_fault_flag;
  assign o_core_divider = power_clock_control[CORE_DIVIDER_LSB +: CORE_DIVIDER_W];
endmodule // clk_pwr_ctrl

/* File: verif/clk_pwr_chk_asserts.sv */
`timescale 1ns/1ns
module clk_pwr_chk
  import clk_pwr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_lock,
  input wire logic i_battery_power_state,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_timekeep_wr,
  input wire logic o_timekeep_unlock,
  input wire logic o_metering_shutdown,
  input wire logic o_core_shutdown,
  input wire logic o_cpu_reset,
  input wire logic o_lock_fault_flag,
  input wire logic [CORE_DIVIDER_W-1:0] o_core_divider
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  wire logic wr_key = i_sfr_wr && i_sfr_addr == UNLOCK_KEY_ADDR;
  wire logic wr_ctl = i_sfr_wr && i_sfr_addr == POWER_CLOCK_CONTROL_ADDR;
  wire logic wr_ack = i_sfr_wr && i_sfr_addr == CONVERSION_START_REG_ADDR && i_sfr_wdata[LOCK_FAULT_ACK_BIT];
  sequence keyed;
    wr_key && i_sfr_wdata == POWER_KEY ##1 wr_ctl;
  endsequence
  AST_KEYED_DIV: assert property (keyed |=> o_core_divider == $past(i_sfr_wdata[2:0]))
    else $error("divider not loaded");
  AST_KEYED_METER: assert property (keyed |=> o_metering_shutdown == $past(i_sfr_wdata[6]))
    else $error("metering shutdown not loaded");
  AST_NOKEY: assert property (wr_key && i_sfr_wdata != POWER_KEY ##1 wr_ctl |=> $stable(o_core_divider))
    else $error("control changed without key");
  AST_CORE_OFF: assert property (!i_battery_power_state [*4] |-> !o_core_shutdown)
    else $error("core stopped outside battery state");
  AST_FAULT_SET: assert property ($fell(i_lock) |-> ##[1:6] (o_lock_fault_flag && o_cpu_reset))
    else $error("lock loss not handled");
  AST_FAULT_ACK: assert property (i_lock [*6] ##0 wr_ack |=> !o_lock_fault_flag)
    else $error("fault flag not cleared");
  AST_TK_KEY: assert property (wr_key ##1 !i_sfr_wr && !i_timekeep_wr |=> o_timekeep_unlock == ($past(i_sfr_wdata, 2) == TIMEKEEP_KEY))
    else $error("timekeeping unlock wrong");
  AST_TK_CLR: assert property (o_timekeep_unlock && i_timekeep_wr && !i_sfr_wr ##1 !i_sfr_wr [*2] |-> !o_timekeep_unlock)
    else $error("key not cleared");
  cover property (keyed);
  cover property ($fell(i_lock));
  cover property (o_timekeep_unlock && i_timekeep_wr);
endmodule // clk_pwr_chk
bind clk_pwr_ctrl clk_pwr_chk clk_pwr_chk_inst (.*);

/* File: verif/sfr_core_model.sv */
`timescale 1ns/1ns
// processor side of the register bus, strobes set at falling edges
module sfr_core_model
  import clk_pwr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_sfr_rdata,
  output logic [7:0] o_sfr_addr = 8'h00,
  output logic [7:0] o_sfr_wdata = 8'h00,
  output logic o_sfr_wr = 1'b0,
  output logic o_sfr_rd = 1'b0
);
  // last=0 keeps the strobe up for a back-to-back write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input bit last);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_wdata = (a == POWER_CLOCK_CONTROL_ADDR) ? (d & 8'hdf) : d;
    o_sfr_wr = 1'b1;
    if (last) begin
      @(negedge i_core_clk);
      o_sfr_wr = 1'b0;
      o_sfr_addr = ~a;
      o_sfr_wdata = ~o_sfr_wdata;
    end
  endtask
  task automatic ctl_wr(input logic [7:0] k, input logic [7:0] d);
    wr_reg(UNLOCK_KEY_ADDR, k, 1'b0);
    wr_reg(POWER_CLOCK_CONTROL_ADDR, d, 1'b1);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_rd = 1'b1;
    @(negedge i_core_clk);
    d = i_sfr_rdata;
    o_sfr_rd = 1'b0;
    o_sfr_addr = ~a;
  endtask
endmodule // sfr_core_model

/* File: verif/test_pll_core_clock_power_control.sv */
`timescale 1ns/1ns
module test_pll_core_clock_power_control;
  import clk_pwr_pkg::*;
  logic i_core_clk, i_rstn, i_ref_clk, i_lock, i_battery_power_state, i_sfr_wr, i_sfr_rd, i_timekeep_wr;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, v, w;
  logic o_sfr_hit, o_timekeep_unlock, o_loop_clk_en, o_core_clk_en, o_meter_clk_en, o_metering_shutdown;
  logic o_core_shutdown, o_cpu_reset, o_lock_fault_flag;
  logic [2:0] o_core_divider;
  logic [7:0] ra [5] = '{8'hc1, 8'hc5, 8'hd8, 8'hf4, 8'h10};
  logic [7:0] re [5] = '{UNLOCK_KEY_RESET, POWER_CLOCK_CONTROL_RESET, 8'h00, 8'h00, 8'h00};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  clk_pwr_ctrl clk_pwr_ctrl_inst (.*);
  sfr_core_model sfr_core_model_inst (.i_core_clk(i_core_clk), .i_sfr_rdata(o_sfr_rdata), .o_sfr_addr(i_sfr_addr),
    .o_sfr_wdata(i_sfr_wdata), .o_sfr_wr(i_sfr_wr), .o_sfr_rd(i_sfr_rd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [7:0] ctl_exp(input logic [7:0] d);
    return {1'b1, d[6], 1'b0, d[4], 1'b0, d[2:0]};
  endfunction
  // loop pulses from one core (or meter) pulse to the next
  task automatic gap(input bit meter, output logic [7:0] cnt);
    int t;
    cnt = 8'h00;
    t = 0;
    while (!(meter ? o_meter_clk_en : o_core_clk_en) && t < 9000) begin
      @(negedge i_core_clk);
      t++;
    end
    do begin
      @(negedge i_core_clk);
      t++;
      if (o_loop_clk_en) cnt++;
    end while (!(meter ? o_meter_clk_en : o_core_clk_en) && t < 9000);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #15259 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    i_rstn = 1'b0;
    i_lock = 1'b1;
    i_battery_power_state = 1'b0;
    i_timekeep_wr = 1'b0;
    v = 8'($urandom(32'he06e));
    repeat (4) @(negedge i_core_clk);
    i_rstn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge i_core_clk);
      sfr_core_model_inst.o_sfr_addr = ra[i];
      #1 chk(o_sfr_hit, 8'(i < 4));
      sfr_core_model_inst.rd_reg(ra[i], v);
      chk(v, re[i]);
    end
    gap(1'b0, v);
    chk(v, 8'h04);
    for (int cd = 0; cd < 8; cd++) begin
      w = {8'($urandom) & 8'hf8} | 8'(cd);
      sfr_core_model_inst.ctl_wr(POWER_KEY, w);
      sfr_core_model_inst.rd_reg(POWER_CLOCK_CONTROL_ADDR, v);
      chk(v, ctl_exp(w & 8'hdf));
      chk(o_metering_shutdown, w[6]);
      chk(o_core_divider, 8'(cd));
      chk(o_core_shutdown, 8'h00);
      gap(1'b0, v);
      chk(v, 8'h01 << cd);
      gap(1'b1, v);
      chk(v, 8'h05);
    end
    sfr_core_model_inst.ctl_wr(8'h55, 8'h00);
    sfr_core_model_inst.ctl_wr(POWER_KEY, 8'h10);
    sfr_core_model_inst.wr_reg(POWER_CLOCK_CONTROL_ADDR, 8'h03, 1'b1);
    sfr_core_model_inst.rd_reg(POWER_CLOCK_CONTROL_ADDR, v);
    chk(v, ctl_exp(8'h10));
    i_battery_power_state = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk(o_core_shutdown, 8'h01);
    i_battery_power_state = 1'b0;
    sfr_core_model_inst.wr_reg(UNLOCK_KEY_ADDR, TIMEKEEP_KEY, 1'b1);
    @(negedge i_core_clk);
    chk(o_timekeep_unlock, 8'h01);
    i_timekeep_wr = 1'b1;
    @(negedge i_core_clk);
    i_timekeep_wr = 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk(o_timekeep_unlock, 8'h00);
    sfr_core_model_inst.rd_reg(UNLOCK_KEY_ADDR, v);
    chk(v, 8'h00);
    i_lock = 1'b0;
    repeat (6) @(negedge i_core_clk);
    chk({o_lock_fault_flag, o_cpu_reset}, 8'h03);
    i_lock = 1'b1;
    n = 6;
    while (o_cpu_reset === 1'b1 && n < 400) begin
      @(negedge i_core_clk);
      n++;
    end
    chk(8'(n >= FAULT_RESET_CYCLES && n <= FAULT_RESET_CYCLES + 6), 8'h01);
    sfr_core_model_inst.rd_reg(PERIPHERAL_CONFIG_ADDR, v);
    chk(v[LOCK_FAULT_FLAG_BIT], 8'h01);
    sfr_core_model_inst.wr_reg(CONVERSION_START_REG_ADDR, 8'h80, 1'b1);
    sfr_core_model_inst.rd_reg(PERIPHERAL_CONFIG_ADDR, v);
    chk(v[LOCK_FAULT_FLAG_BIT], 8'h00);
    finish_test();
  end
endmodule // test_pll_core_clock_power_control
